// ### core/upgrade_defines.vh
// constants for the remote upgrade register set
`ifndef UPGRADE_DEFINES_VH
`define UPGRADE_DEFINES_VH

// control register layout
`define CTL_WIDTH          39
`define CTL_RSV_HIGH       38
`define CTL_EARLY_DONE     37
`define CTL_OSC_STARTUP    36
`define CTL_WD_ENABLE      35
`define CTL_RSV_LOW        34
`define CTL_ADDR_MSB       33
`define CTL_ADDR_LSB       12
`define CTL_WD_MSB         11
`define CTL_WD_LSB         0

// status register width
`define STAT_WIDTH         32

// power-up factory addresses (24-bit boot address)
`define SERIAL_FACTORY_ADDR   24'h000000
`define PARALLEL_FACTORY_ADDR 24'h010000

// fixed low part of the watchdog count
`define WD_LOW_FILL        17'b1000

// cause codes for the status register
`define CAUSE_CONFIG_PIN   4'h8
`define CAUSE_CRC          4'h4
`define CAUSE_STATUS_PIN   4'h2
`define CAUSE_WATCHDOG     4'h1

// oscillator period in ns and derived tick divider of the system clock
`define OSC_PERIOD_NS      100
`define SYS_PERIOD_NS      40
`define OSC_DIV_CYCLES     ((`OSC_PERIOD_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)

`endif

// ### core/pin_sync.v
// two-flop synchroniser for one pin level
`default_nettype none

module pin_sync
(
  // clock and reset
  input  wire CLK_SYS,
  input  wire RST_B,
  // pin and synchronised level
  input  wire pin,
  output reg  level
);

  reg meta;

  // first flop read only by the second
  always @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      meta  <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      meta  <= pin;
      level <= meta;
    end
  end

endmodule // pin_sync
`default_nettype wire

// ### core/osc_tick.v
// tick generator standing in for the internal oscillator rate
`default_nettype none
`include "upgrade_defines.vh"

module osc_tick
(
  // clock and reset
  input  wire CLK_SYS,
  input  wire RST_B,
  // one-cycle tick at oscillator rate
  output reg  tick
);

  // divider is a few cycles, so four bits of the full count are enough
  localparam integer DIV_FULL = `OSC_DIV_CYCLES;
  localparam [3:0]   DIV      = DIV_FULL[3:0];

  reg [3:0] count;

  // rounds the oscillator period up to whole system cycles
  always @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      count <= 4'h0;
      tick  <= 1'b0;
    end
    else if (count == DIV - 4'h1)
    begin
      count <= 4'h0;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 4'h1;
      tick  <= 1'b0;
    end
  end

endmodule // osc_tick
`default_nettype wire

// ### core/upgrade_regs.v
// remote upgrade register set: shift, update, control and status registers
//
// Behaviour
// [RULE1] shift register gives fabric serial access to update, status, control (code never loads the control register into the shift register)
// [RULE2] factory image may transfer shift contents into update register
// [RULE3] application image: every write through the shift register is blocked
// [RULE4] read in application image loads control register into shift (code loads the status register instead)
// [RULE5] reconfiguration start copies update register into control register
// [RULE6] fabric changes update only by shifting then issuing an update
// [RULE7] read in factory image loads update register into shift
// [RULE8] status register written on every reconfiguration with its cause
// [RULE9] capture cycle moves status register into the shift register (code does so in application image only; factory image loads update)
// [RULE10] control and status plus watchdog run on oscillator timing
// [RULE11] shift and update registers run on the user-supplied clock
// [RULE12] serial scheme power-up clears control address bits to zero
// [RULE13] parallel scheme power-up sets address to default factory location
// [RULE14] test-port instruction can replace the parallel factory address
// [RULE15] factory image has write access to control register contents
// [RULE16] control register is 39 bits with fixed field positions
// [RULE17] watchdog count is timeout field above fixed 17-bit fill
// [RULE18] boot address is address field with two zero bits appended
// [RULE19] early done check verifies image exists at boot address
// [RULE20] startup clock option selects internal oscillator for startup
// [RULE21] factory image should set both option bits for application
// [RULE22] watchdog enable bit turns watchdog on for application image
// [RULE23] watchdog always disabled while factory image runs
// [RULE24] status written on status pin low, crc error, timeout, reset
// [RULE25] shift when selected; else capture or update per select
`default_nettype none
`include "upgrade_defines.vh"

module upgrade_regs
(
  // system clock and reset
  input  wire                   CLK_SYS,
  input  wire                   RST_B,
  // boot scheme and image straps
  input  wire                   PARALLEL_BOOT_SCHEME,
  input  wire                   FACTORY_IMAGE,
  // test-port replacement of parallel factory address
  input  wire                   PARALLEL_FACTORY_ADDR_INSTR,
  input  wire [23:0]            PARALLEL_FACTORY_ADDR_VALUE,
  // fabric serial access
  input  wire                   UPGRADE_USER_CLOCK,
  input  wire                   UPGRADE_SERIAL_IN,
  input  wire                   SHIFT_OR_LOAD_SEL,
  input  wire                   CAPTURE_OR_UPDATE_SEL,
  output reg                    UPGRADE_SERIAL_OUT,
  // reconfiguration sources
  input  wire                   CONFIG_REQUEST_PIN_B,
  input  wire                   CONFIG_STATUS_PIN_B,
  input  wire                   CRC_ERROR,
  input  wire                   WATCHDOG_TIMEOUT,
  input  wire                   IMAGE_VALID,
  // configuration controls
  output reg                    RECONFIG_START,
  output reg  [23:0]            BOOT_ADDRESS,
  output reg  [28:0]            WATCHDOG_COUNT,
  output reg                    WATCHDOG_RUN,
  output reg                    EARLY_DONE_FAIL,
  output reg                    STARTUP_CLOCK_OSC,
  output reg  [`CTL_WIDTH-1:0]  CONTROL_VALUE,
  output reg  [`STAT_WIDTH-1:0] STATUS_VALUE
);

  // ************************************************************
  // synchronisers
  // ************************************************************
  wire clk_s, din_s, shift_s, capt_s, cfg_b_s, stat_b_s;

  pin_sync u_clk (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .pin(UPGRADE_USER_CLOCK), .level(clk_s));
  pin_sync u_din (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .pin(UPGRADE_SERIAL_IN), .level(din_s));
  pin_sync u_sft (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .pin(SHIFT_OR_LOAD_SEL), .level(shift_s));
  pin_sync u_cap (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .pin(CAPTURE_OR_UPDATE_SEL), .level(capt_s));
  pin_sync u_cfg (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .pin(CONFIG_REQUEST_PIN_B), .level(cfg_b_s));
  pin_sync u_sts (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .pin(CONFIG_STATUS_PIN_B), .level(stat_b_s));

  // oscillator-rate tick for control and status timing
  wire osc_tick_w;

  osc_tick u_osc (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .tick(osc_tick_w)); // [RULE10]

  // ************************************************************
  // user clock rise and pin fall edge detection
  // ************************************************************
  reg clk_d;
  reg cfg_d;
  reg stat_d;

  always @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      clk_d  <= 1'b0;
      cfg_d  <= 1'b1;
      stat_d <= 1'b1;
    end
    else
    begin
      clk_d  <= clk_s;
      cfg_d  <= cfg_b_s;
      stat_d <= stat_b_s;
    end
  end

  wire user_rise = clk_s & ~clk_d; // [RULE11]
  wire cfg_fall  = cfg_d & ~cfg_b_s;
  wire stat_fall = stat_d & ~stat_b_s;

  // ************************************************************
  // straps caught after reset release
  // ************************************************************
  reg        started;
  reg        parallel;
  reg [23:0] factory_addr;

  // strap decoded straight from the pin, so the first load sees the right scheme
  wire [23:0] power_addr = PARALLEL_BOOT_SCHEME ? `PARALLEL_FACTORY_ADDR : `SERIAL_FACTORY_ADDR; // [RULE12] [RULE13]

  always @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      started      <= 1'b0;
      parallel     <= 1'b0;
      factory_addr <= 24'h000000;
    end
    else if (!started)
    begin
      started      <= 1'b1;
      parallel     <= PARALLEL_BOOT_SCHEME;
      factory_addr <= power_addr; // [RULE12] [RULE13]
    end
    else if (parallel && PARALLEL_FACTORY_ADDR_INSTR)
      factory_addr <= PARALLEL_FACTORY_ADDR_VALUE; // [RULE14]
  end

  // ************************************************************
  // shift and update registers (user clock edges)
  // ************************************************************
  reg [`CTL_WIDTH-1:0] shifter;
  reg [`CTL_WIDTH-1:0] update;
  reg [`CTL_WIDTH-1:0] control;
  reg [`STAT_WIDTH-1:0] status;

  // read source depends on which image runs
  wire [`CTL_WIDTH-1:0] read_src = FACTORY_IMAGE ? update : control; // [RULE4] [RULE7]
  wire                  write_ok = FACTORY_IMAGE;                    // [RULE2] [RULE3]

  always @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      shifter <= {`CTL_WIDTH{1'b0}};
      update  <= {`CTL_WIDTH{1'b0}};
    end
    else if (!started)
      update <= {4'h0, 1'b0, power_addr[23:2], 12'h000};
    else if (user_rise)
    begin
      if (shift_s)
      begin
        // shift only alters the shifter, so it is not a write
        shifter <= {din_s, shifter[`CTL_WIDTH-1:1]}; // [RULE1] [RULE25]
      end
      else if (capt_s)
      begin
        // factory image captures the update register, application image the status register
        if (FACTORY_IMAGE)
          shifter <= read_src; // [RULE7]
        else
          shifter <= {{(`CTL_WIDTH-`STAT_WIDTH){1'b0}}, status}; // [RULE9]
      end
      else if (write_ok)
        update <= shifter; // [RULE2] [RULE6] [RULE15]
    end
  end

  // ************************************************************
  // reconfiguration and control/status registers
  // ************************************************************
  reg [3:0] pending;

  wire [3:0] new_cause = {cfg_fall, CRC_ERROR, stat_fall, WATCHDOG_TIMEOUT}; // [RULE24]

  // causes accumulate until the next oscillator tick commits them
  always @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      pending        <= 4'h0;
      control        <= {`CTL_WIDTH{1'b0}};
      status         <= {`STAT_WIDTH{1'b0}};
      RECONFIG_START <= 1'b0;
    end
    else if (!started)
    begin
      control        <= {4'h0, 1'b0, power_addr[23:2], 12'h000}; // [RULE12] [RULE13]
      RECONFIG_START <= 1'b0;
    end
    else if (parallel && PARALLEL_FACTORY_ADDR_INSTR)
    begin
      // replaced factory address takes effect in the control address bits
      control        <= {4'h0, 1'b0, PARALLEL_FACTORY_ADDR_VALUE[23:2], 12'h000}; // [RULE14]
      pending        <= pending | new_cause;
      RECONFIG_START <= 1'b0;
    end
    else if (osc_tick_w && (pending != 4'h0 || new_cause != 4'h0))
    begin
      pending        <= 4'h0;
      control        <= update; // [RULE5]
      status         <= {28'h0000000, pending | new_cause}; // [RULE8]
      RECONFIG_START <= 1'b1;
    end
    else
    begin
      pending        <= pending | new_cause;
      RECONFIG_START <= 1'b0;
    end
  end

  // ************************************************************
  // derived controls from the control register
  // ************************************************************
  always @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      BOOT_ADDRESS       <= 24'h000000;
      WATCHDOG_COUNT     <= 29'h00000000;
      WATCHDOG_RUN       <= 1'b0;
      EARLY_DONE_FAIL    <= 1'b0;
      STARTUP_CLOCK_OSC  <= 1'b0;
      CONTROL_VALUE      <= {`CTL_WIDTH{1'b0}};
      STATUS_VALUE       <= {`STAT_WIDTH{1'b0}};
      UPGRADE_SERIAL_OUT <= 1'b0;
    end
    else
    begin
      BOOT_ADDRESS       <= {control[`CTL_ADDR_MSB:`CTL_ADDR_LSB], 2'b00};                  // [RULE16] [RULE18]
      WATCHDOG_COUNT     <= {control[`CTL_WD_MSB:`CTL_WD_LSB], `WD_LOW_FILL};                // [RULE17]
      WATCHDOG_RUN       <= control[`CTL_WD_ENABLE] & ~FACTORY_IMAGE;                        // [RULE22] [RULE23]
      EARLY_DONE_FAIL    <= control[`CTL_EARLY_DONE] & ~FACTORY_IMAGE & ~IMAGE_VALID;         // [RULE19]
      STARTUP_CLOCK_OSC  <= control[`CTL_OSC_STARTUP];                                       // [RULE20]
      CONTROL_VALUE      <= control;
      STATUS_VALUE       <= status;
      UPGRADE_SERIAL_OUT <= shifter[0]; // [RULE25]
    end
  end

endmodule // upgrade_regs
`default_nettype wire

// ### test/upgrade_regs_properties.sv
// assertion checker for the upgrade register set
`default_nettype none
module upgrade_regs_properties (
  input wire logic        CLK_SYS, RST_B, FACTORY_IMAGE, CRC_ERROR, CONFIG_REQUEST_PIN_B,
  input wire logic        RECONFIG_START, WATCHDOG_RUN, STARTUP_CLOCK_OSC,
  input wire logic [23:0] BOOT_ADDRESS,
  input wire logic [28:0] WATCHDOG_COUNT,
  input wire logic [38:0] CONTROL_VALUE,
  input wire logic [31:0] STATUS_VALUE
);
  logic [1:0] up;
  // outputs lag reset release by two edges; the form and enable checks are held off for three edges, until up reaches 3
  always_ff @(posedge CLK_SYS)
    if (!RST_B)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);
  a_boot_addr_form: assert property (up == 2'h3 |-> BOOT_ADDRESS == {CONTROL_VALUE[33:12], 2'h0})
    else $error("boot address not built from address field");
  a_wd_count_form: assert property (up == 2'h3 |-> WATCHDOG_COUNT == {CONTROL_VALUE[11:0], 17'h8})
    else $error("watchdog count not built from timeout field");
  a_osc_option_out: assert property (up == 2'h3 |-> STARTUP_CLOCK_OSC == CONTROL_VALUE[36])
    else $error("startup clock choice differs from option bit");
  a_wd_factory_off: assert property (FACTORY_IMAGE [*3] |-> !WATCHDOG_RUN)
    else $error("watchdog runs under factory image");
  a_wd_app_enable: assert property ((up == 2'h3 && !FACTORY_IMAGE) [*3] |-> WATCHDOG_RUN == CONTROL_VALUE[35])
    else $error("watchdog run differs from enable bit");
  a_start_one_cycle: assert property (RECONFIG_START |=> !RECONFIG_START)
    else $error("reconfiguration start longer than one cycle");
  a_request_starts: assert property ($fell(CONFIG_REQUEST_PIN_B) |-> ##[1:12] RECONFIG_START)
    else $error("config request gave no reconfiguration");
  a_crc_recorded: assert property ($rose(CRC_ERROR) |-> ##[1:12] STATUS_VALUE[3:0] == 4'h4)
    else $error("crc cause not recorded");
  c_start: cover property (RECONFIG_START);
  c_crc: cover property (STATUS_VALUE[2]);
  c_wd_run: cover property (WATCHDOG_RUN);
endmodule // upgrade_regs_properties
bind upgrade_regs upgrade_regs_properties chk (.*);
`default_nettype wire

// ### test/upgrade_fabric_model.sv
// fabric-side model driving the serial register access
`default_nettype none
module upgrade_fabric_model (
  // pacing clock
  input  wire logic clk,
  // serial link
  input  wire logic dout,
  output var  logic uclk, din, shsel, cusel
);
  timeunit 1ns;
  timeprecision 1ns;
  // link clock stands low between frames
  initial
  begin
    uclk = 1'b0;
    din = 1'b0;
    shsel = 1'b1;
    cusel = 1'b1;
  end
  // one 320 ns link clock period
  task automatic pulse;
    uclk <= 1'b1;
    repeat (4) @(posedge clk);
    uclk <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // 39 bits lsb first, outgoing bit taken before each edge
  task automatic frame(input logic [38:0] d, output logic [38:0] q);
    for (int i = 0; i < 39; i++)
    begin
      q[i] = dout;
      din <= d[i];
      @(posedge clk);
      pulse;
    end
    din <= ~d[38]; // idle data never repeats the last bit
  endtask
  // capture when c is high, update when low
  task automatic op(input logic c);
    shsel <= 1'b0;
    cusel <= c;
    @(posedge clk);
    pulse;
    shsel <= 1'b1;
    @(posedge clk);
  endtask
endmodule // upgrade_fabric_model
`default_nettype wire

// ### test/upgrade_regs_tb_top.sv
// self-checking testbench for the upgrade register set
`default_nettype none
module upgrade_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS = 0, RST_B = 0, PARALLEL_BOOT_SCHEME = 0, FACTORY_IMAGE = 1, PARALLEL_FACTORY_ADDR_INSTR = 0;
  logic CONFIG_REQUEST_PIN_B = 1, CONFIG_STATUS_PIN_B = 1, CRC_ERROR = 0, WATCHDOG_TIMEOUT = 0, IMAGE_VALID = 1;
  logic [23:0] PARALLEL_FACTORY_ADDR_VALUE = 24'h2a0004;
  wire UPGRADE_USER_CLOCK, UPGRADE_SERIAL_IN, SHIFT_OR_LOAD_SEL, CAPTURE_OR_UPDATE_SEL, UPGRADE_SERIAL_OUT;
  wire RECONFIG_START, WATCHDOG_RUN, EARLY_DONE_FAIL, STARTUP_CLOCK_OSC;
  wire [23:0] BOOT_ADDRESS;
  wire [28:0] WATCHDOG_COUNT;
  wire [38:0] CONTROL_VALUE;
  wire [31:0] STATUS_VALUE;
  int n_mismatch = 0;
  int total_checks = 0;
  // both option bits set, watchdog on, as the factory image should
  localparam logic [38:0] W = {5'b01110, 22'h0abcde, 12'h5a3};
  upgrade_regs dut (.*);
  upgrade_fabric_model fab (.clk(CLK_SYS), .dout(UPGRADE_SERIAL_OUT), .uclk(UPGRADE_USER_CLOCK),
    .din(UPGRADE_SERIAL_IN), .shsel(SHIFT_OR_LOAD_SEL), .cusel(CAPTURE_OR_UPDATE_SEL));
  always #20 CLK_SYS = ~CLK_SYS;
  task automatic chk(input logic [38:0] seen, input logic [38:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset(input logic par, input logic instr, input logic [23:0] exp);
    RST_B <= 1'b0;
    PARALLEL_BOOT_SCHEME <= par;
    PARALLEL_FACTORY_ADDR_INSTR <= instr;
    repeat (3) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    repeat (6) @(posedge CLK_SYS);
    PARALLEL_FACTORY_ADDR_INSTR <= 1'b0;
    chk(BOOT_ADDRESS, exp);
    chk(CONTROL_VALUE[33:12], exp[23:2]);
  endtask
  // pins need a few cycles to pass the synchronisers
  task automatic fire(input int k, input logic [3:0] exp);
    int n;
    case (k)
      0: CONFIG_REQUEST_PIN_B <= 1'b0;
      1: CRC_ERROR <= 1'b1;
      2: CONFIG_STATUS_PIN_B <= 1'b0;
      default: WATCHDOG_TIMEOUT <= 1'b1;
    endcase
    repeat (k[0] ? 1 : 4) @(posedge CLK_SYS);
    {CONFIG_REQUEST_PIN_B, CRC_ERROR, CONFIG_STATUS_PIN_B, WATCHDOG_TIMEOUT} <= 4'ha;
    n = 0;
    do
    begin
      @(posedge CLK_SYS);
      n++;
    end while (RECONFIG_START !== 1'b1 && n < 30);
    chk(RECONFIG_START, 1'b1);
    repeat (3) @(posedge CLK_SYS);
    chk(STATUS_VALUE[3:0], exp);
  endtask
  task automatic t_power_up;
    do_reset(1'b0, 1'b0, 24'h000000);
    do_reset(1'b1, 1'b0, 24'h010000);
    do_reset(1'b1, 1'b1, 24'h2a0004);
    $display("power-up test done");
  endtask
  task automatic t_factory;
    logic [38:0] q;
    fab.frame(W, q);
    fab.op(1'b0);
    fab.op(1'b1);
    fab.frame(39'h0, q);
    chk(q, W);
    fire(0, 4'h8);
    chk(CONTROL_VALUE, W);
    chk(BOOT_ADDRESS, 24'h2af378);
    chk(WATCHDOG_COUNT, {12'h5a3, 17'h8});
    chk(STARTUP_CLOCK_OSC, 1'b1);
    chk(WATCHDOG_RUN, 1'b0);
    chk(EARLY_DONE_FAIL, 1'b0);
    $display("factory test done");
  endtask
  // writes refused under the application image, crc, status pin and watchdog causes recorded
  task automatic t_app;
    logic [38:0] q;
    FACTORY_IMAGE <= 1'b0;
    IMAGE_VALID <= 1'b0;
    fab.frame(~W, q);
    fab.op(1'b0);
    fab.op(1'b1);
    fab.frame(39'h0, q);
    chk(q[3:0], 4'h8);
    chk(WATCHDOG_RUN, 1'b1);
    fire(1, 4'h4);
    chk(CONTROL_VALUE, W);
    chk(EARLY_DONE_FAIL, 1'b1);
    IMAGE_VALID <= 1'b1;
    fire(2, 4'h2);
    fire(3, 4'h1);
    chk(EARLY_DONE_FAIL, 1'b0);
    $display("application test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard at 10000 cycles, well beyond the roughly 1500 cycles expected
  initial
  begin
    #400000;
    n_mismatch++;
    close_out;
  end
  initial
  begin
    t_power_up;
    t_factory;
    t_app;
    close_out;
  end
endmodule // upgrade_regs_tb_top
`default_nettype wire
